// ===== logic/bbc_pkg.sv
// package: constants and carriers for the bit, branch and compare slice
// assumes: 16-bit opcodes, 32-bit data, sixteen general registers
package bbc_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int unsigned DATA_W = 32;
    localparam int unsigned OP_W = 16;
    localparam int unsigned SEL_W = 4;
    localparam int unsigned NREG = 16;
    localparam int unsigned LIT_W = 5;
    localparam int unsigned DISP_W = 11;

    // ------------------------------------------------------------
    // opcode patterns and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] OPC_ONEHOT = 8'h13;
    localparam logic [7:0] OPC_CMP_UNS = 8'h0C;
    localparam logic [7:0] OPC_CMP_SGN = 8'h0D;
    localparam logic [4:0] OPC_JUMP = 5'h1E;
    localparam logic [4:0] OPC_CALL = 5'h1F;
    localparam logic [4:0] OPC_JUMP_T = 5'h1C;
    localparam logic [6:0] OPC_MASK = 7'h16;
    localparam logic [6:0] OPC_BITSET = 7'h1A;
    localparam logic [6:0] OPC_BITTST = 7'h1B;
    localparam logic [11:0] OPC_REVERSE = 12'h00F;
    localparam logic [11:0] OPC_CLR_F = 12'h01D;
    localparam logic [11:0] OPC_CLR_T = 12'h01C;
    localparam logic [15:0] OPC_BREAK = 16'h0000;
    localparam logic [4:0] MASK_MIN_LIT = 5'h08;
    localparam logic [4:0] LIT_ZERO = 5'h00;
    localparam logic [3:0] LINK_SEL = 4'hF;
    localparam int unsigned SRC_HI = 7;
    localparam int unsigned SRC_LO = 4;
    localparam int unsigned DST_HI = 3;
    localparam int unsigned LIT_HI = 8;
    localparam int unsigned LIT_LO = 4;
    localparam int unsigned ONEHOT_OFF_BIT = 5;
    localparam logic [31:0] PC_STEP = 32'h0000_0002;
    localparam logic [31:0] ALL_ONES = 32'hFFFF_FFFF;
    localparam logic [31:0] ZERO_W = 32'h0000_0000;
    localparam logic [31:0] ONE_W = 32'h0000_0001;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic [OP_W-1:0] opcode;
        logic [DATA_W-1:0] pc;
    } fetch_t;

    typedef struct packed {
        logic wr_en;
        logic [SEL_W-1:0] wr_sel;
        logic [DATA_W-1:0] wr_data;
    } reg_wr_t;

    typedef struct packed {
        logic pc_load;
        logic [DATA_W-1:0] pc_next;
        logic breakpoint;
        logic illegal;
    } flow_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01
    } exec_state_t;

endpackage : bbc_pkg

// ===== logic/reg_file16.sv
// file: sixteen-entry general register file, two read ports, one write
// assumes: single clock, synchronous active-low reset, read in a write cycle sees the old word
`timescale 1ns/100ps
module reg_file16 (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic ce_in,
    // read ports
    input wire logic [bbc_pkg::SEL_W-1:0] rd_a_sel_in,
    input wire logic [bbc_pkg::SEL_W-1:0] rd_b_sel_in,
    output logic [bbc_pkg::DATA_W-1:0] rd_a_out,
    output logic [bbc_pkg::DATA_W-1:0] rd_b_out,
    // write port
    input wire bbc_pkg::reg_wr_t wr_in
);
    logic [bbc_pkg::DATA_W-1:0] mem_reg [bbc_pkg::NREG];

    // selector code n addresses register n
    assign rd_a_out = mem_reg[rd_a_sel_in];
    assign rd_b_out = mem_reg[rd_b_sel_in];

    // one write per enabled cycle
    genvar gi;
    generate
        for (gi = 0; gi < bbc_pkg::NREG; gi++) begin : g_word
            always_ff @(posedge mclk_in) begin
                if (!rst_b_in) begin
                    mem_reg[gi] <= bbc_pkg::ZERO_W;
                end else if (ce_in && wr_in.wr_en
                             && wr_in.wr_sel == bbc_pkg::SEL_W'(gi)) begin
                    mem_reg[gi] <= wr_in.wr_data;
                end
            end
        end
    endgenerate
endmodule : reg_file16

// ===== logic/bit_branch_compare_exec.sv
// file: decode and execute slice for bit, branch and compare opcodes
// assumes: fetch presents one opcode with its pc; one opcode per cycle
// How it works
// - one-hot: src bit5 clear gives single bit at src[4:0], else zero
// - one-hot decoded at opcode[15:8]=00010011, src 7:4, dst 3:0
// - four-bit selector n picks register n of sixteen
// - all-zero opcode raises the breakpoint exception
// - mask sets low N bits; literal zero means all 32 set
// - mask literals 1 through 7 are not mask; 8 upward are
// - jump target is pc plus two plus doubled sign-extended displacement
// - unconditional jump decoded at opcode[15:11]=11110
// - call at 11111 writes pc plus two into link_reg then jumps
// - jump_if_flag_set jumps only with flag one, else pc plus two
// - reverse mirrors the destination register bit order
// - bit-set at 0011010 sets literal-indexed bit, others unchanged
// - bit-test at 0011011 copies literal-indexed bit into flag
// - clear-if-false zeroes destination when flag is zero
// - clear-if-true zeroes destination when flag is one
// - signed compare sets flag when first < second
`timescale 1ns/100ps
module bit_branch_compare_exec (
    // clock, reset, enable
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic ce_in,
    // fetch side
    input wire bbc_pkg::fetch_t fetch_in,
    // flow and exceptions
    output bbc_pkg::flow_t flow_out,
    output logic exec_done_out,
    // condition flag of the processor_state_word
    output logic flag_out,
    // register observation
    input wire logic [bbc_pkg::SEL_W-1:0] dbg_sel_in,
    output logic [bbc_pkg::DATA_W-1:0] dbg_data_out
);

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------
    function automatic logic [31:0] one_hot(input logic [4:0] idx);
        one_hot = bbc_pkg::ONE_W << idx;
    endfunction : one_hot

    // ------------------------------------------------------------
    // field extraction
    // ------------------------------------------------------------
    logic [15:0] op;
    logic [3:0] src_reg_sel;
    logic [3:0] dst_sel;
    logic [4:0] five_bit_literal;
    logic [31:0] disp_ext;
    logic [31:0] pc_plus2;
    logic [31:0] jump_target;
    assign op = fetch_in.opcode;
    assign src_reg_sel = op[bbc_pkg::SRC_HI:bbc_pkg::SRC_LO];
    assign dst_sel = op[bbc_pkg::DST_HI:0];
    assign five_bit_literal = op[bbc_pkg::LIT_HI:bbc_pkg::LIT_LO];
    // sign-extend and scale to half-words
    assign disp_ext = {{(32-bbc_pkg::DISP_W-1){op[bbc_pkg::DISP_W-1]}},
                       op[bbc_pkg::DISP_W-1:0], 1'b0};
    assign pc_plus2 = fetch_in.pc + bbc_pkg::PC_STEP;
    assign jump_target = pc_plus2 + disp_ext;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic is_onehot, is_cmpu, is_cmps, is_jump, is_call, is_jump_t;
    logic is_mask_slot, is_mask, is_set, is_tst, is_rev, is_clrf, is_clrt;
    logic is_break, is_known;
    assign is_onehot = op[15:8] == bbc_pkg::OPC_ONEHOT;
    assign is_cmpu = op[15:8] == bbc_pkg::OPC_CMP_UNS;
    assign is_cmps = op[15:8] == bbc_pkg::OPC_CMP_SGN;
    assign is_jump = op[15:11] == bbc_pkg::OPC_JUMP;
    assign is_call = op[15:11] == bbc_pkg::OPC_CALL;
    assign is_jump_t = op[15:11] == bbc_pkg::OPC_JUMP_T;
    assign is_mask_slot = op[15:9] == bbc_pkg::OPC_MASK;
    // literals 1..7 belong to other opcodes
    assign is_mask = is_mask_slot
        && (five_bit_literal == bbc_pkg::LIT_ZERO
            || five_bit_literal >= bbc_pkg::MASK_MIN_LIT);
    assign is_set = op[15:9] == bbc_pkg::OPC_BITSET;
    assign is_tst = op[15:9] == bbc_pkg::OPC_BITTST;
    assign is_rev = op[15:4] == bbc_pkg::OPC_REVERSE;
    assign is_clrf = op[15:4] == bbc_pkg::OPC_CLR_F;
    assign is_clrt = op[15:4] == bbc_pkg::OPC_CLR_T;
    assign is_break = op == bbc_pkg::OPC_BREAK;
    assign is_known = is_onehot | is_cmpu | is_cmps | is_jump | is_call
        | is_jump_t | is_mask | is_set | is_tst | is_rev | is_clrf
        | is_clrt | is_break;

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [31:0] src_val, dst_val;
    bbc_pkg::reg_wr_t wr;
    logic [3:0] rd_a_sel;
    logic fire;
    logic dbg_mode;
    assign fire = ce_in && fetch_in.valid;
    assign dbg_mode = !fetch_in.valid;
    assign rd_a_sel = dbg_mode ? dbg_sel_in : src_reg_sel;

    reg_file16 u_regs (
        .mclk_in(mclk_in),
        .rst_b_in(rst_b_in),
        .ce_in(ce_in),
        .rd_a_sel_in(rd_a_sel),
        .rd_b_sel_in(dst_sel),
        .rd_a_out(src_val),
        .rd_b_out(dst_val),
        .wr_in(wr)
    );

    // ------------------------------------------------------------
    // result datapath
    // ------------------------------------------------------------
    logic [31:0] onehot_val, mask_val, rev_val, set_val;
    logic [31:0] wr_data;
    logic flag_reg, flag_next;
    // mirrored bit order
    genvar gb;
    generate
        for (gb = 0; gb < bbc_pkg::DATA_W; gb++) begin : g_rev
            assign rev_val[gb] = dst_val[bbc_pkg::DATA_W-1-gb];
        end
    endgenerate
    // one-hot of source low bits unless bit 5 set
    assign onehot_val = src_val[bbc_pkg::ONEHOT_OFF_BIT]
        ? bbc_pkg::ZERO_W : one_hot(src_val[4:0]);
    // low N ones; zero literal means all ones
    assign mask_val = (five_bit_literal == bbc_pkg::LIT_ZERO)
        ? bbc_pkg::ALL_ONES : one_hot(five_bit_literal) - bbc_pkg::ONE_W;
    assign set_val = dst_val | one_hot(five_bit_literal);

    // write select: second operand of compares is src, first is dst
    always_comb begin
        wr.wr_en = 1'b0;
        wr.wr_sel = dst_sel;
        wr.wr_data = bbc_pkg::ZERO_W;
        if (fire) begin
            if (is_onehot) begin
                wr.wr_en = 1'b1;
                wr.wr_data = onehot_val;
            end else if (is_mask) begin
                wr.wr_en = 1'b1;
                wr.wr_data = mask_val;
            end else if (is_rev) begin
                wr.wr_en = 1'b1;
                wr.wr_data = rev_val;
            end else if (is_set) begin
                wr.wr_en = 1'b1;
                wr.wr_data = set_val;
            end else if (is_clrf) begin
                wr.wr_en = !flag_reg;
            end else if (is_clrt) begin
                wr.wr_en = flag_reg;
            end else if (is_call) begin
                wr.wr_en = 1'b1;
                wr.wr_sel = bbc_pkg::LINK_SEL;
                wr.wr_data = pc_plus2;
            end
        end
    end
    assign wr_data = wr.wr_data;

    // ------------------------------------------------------------
    // condition flag
    // ------------------------------------------------------------
    always_comb begin
        flag_next = flag_reg;
        if (fire && is_tst) begin
            flag_next = dst_val[five_bit_literal];
        end else if (fire && is_cmpu) begin
            flag_next = dst_val >= src_val;
        end else if (fire && is_cmps) begin
            flag_next = $signed(dst_val) < $signed(src_val);
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            flag_reg <= 1'b0;
        end else if (ce_in) begin
            flag_reg <= flag_next;
        end
    end

    // ------------------------------------------------------------
    // flow and exception outputs, registered
    // ------------------------------------------------------------
    bbc_pkg::flow_t flow_reg, flow_next;
    logic done_reg;
    logic [31:0] dbg_reg;
    always_comb begin
        flow_next.pc_load = fire;
        flow_next.breakpoint = fire && is_break;
        flow_next.illegal = fire && !is_known;
        flow_next.pc_next = pc_plus2;
        if (is_jump || is_call || (is_jump_t && flag_reg)) begin
            flow_next.pc_next = jump_target;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            flow_reg <= '0;
            done_reg <= 1'b0;
            dbg_reg <= bbc_pkg::ZERO_W;
        end else if (ce_in) begin
            flow_reg <= flow_next;
            done_reg <= fire;
            dbg_reg <= src_val;
        end
    end

    assign flow_out = flow_reg;
    assign exec_done_out = done_reg;
    assign flag_out = flag_reg;
    assign dbg_data_out = dbg_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // flow and exception results one cycle after the opcode; call link write in the opcode's cycle
    a_break_raises: assert property (
        @(posedge mclk_in) disable iff (!rst_b_in)
        fire && is_break |=> flow_out.breakpoint)
        else $error("breakpoint not raised");
    a_jump_target: assert property (
        @(posedge mclk_in) disable iff (!rst_b_in)
        fire && is_jump |=> flow_out.pc_next == $past(jump_target))
        else $error("jump target wrong");
    a_jumpt_skip: assert property (
        @(posedge mclk_in) disable iff (!rst_b_in)
        fire && is_jump_t && !flag_reg
        |=> flow_out.pc_next == $past(pc_plus2))
        else $error("untaken jump did not step");
    a_jumpt_take: assert property (
        @(posedge mclk_in) disable iff (!rst_b_in)
        fire && is_jump_t && flag_reg
        |=> flow_out.pc_next == $past(jump_target))
        else $error("taken jump target wrong");
    a_call_target: assert property (
        @(posedge mclk_in) disable iff (!rst_b_in)
        fire && is_call |=> flow_out.pc_next == $past(jump_target))
        else $error("call target wrong");
    a_call_link: assert property (
        @(posedge mclk_in) disable iff (!rst_b_in)
        fire && is_call |-> wr.wr_en && wr.wr_sel == bbc_pkg::LINK_SEL
        && wr_data == pc_plus2)
        else $error("call link write wrong");

    // refused literals write nothing and are flagged next cycle
    a_mask_reserved: assert property (
        @(posedge mclk_in) disable iff (!rst_b_in)
        fire && is_mask_slot && five_bit_literal != bbc_pkg::LIT_ZERO
        && five_bit_literal < bbc_pkg::MASK_MIN_LIT
        |-> !wr.wr_en ##1 flow_out.illegal)
        else $error("reserved mask literal executed");

    // register results
    a_mask_low: assert property (
        @(posedge mclk_in) disable iff (!rst_b_in)
        fire && is_mask && five_bit_literal != bbc_pkg::LIT_ZERO
        |-> wr.wr_en && wr_data
            == bbc_pkg::ALL_ONES >> (bbc_pkg::DATA_W - five_bit_literal))
        else $error("mask width wrong");
    a_mask_all: assert property (
        @(posedge mclk_in) disable iff (!rst_b_in)
        fire && is_mask && five_bit_literal == bbc_pkg::LIT_ZERO
        |-> wr.wr_en && wr_data == bbc_pkg::ALL_ONES)
        else $error("zero literal mask not all ones");
    a_onehot_val: assert property (
        @(posedge mclk_in) disable iff (!rst_b_in)
        fire && is_onehot && src_val[bbc_pkg::ONEHOT_OFF_BIT]
        |-> wr.wr_en && wr_data == bbc_pkg::ZERO_W)
        else $error("one-hot with bit5 not zero");
    a_onehot_hit: assert property (
        @(posedge mclk_in) disable iff (!rst_b_in)
        fire && is_onehot && !src_val[bbc_pkg::ONEHOT_OFF_BIT]
        |-> wr.wr_en && $onehot(wr_data) && wr_data[src_val[4:0]])
        else $error("one-hot bit misplaced");
    a_rev_ends: assert property (
        @(posedge mclk_in) disable iff (!rst_b_in)
        fire && is_rev |-> wr.wr_en
        && wr_data[0] == dst_val[bbc_pkg::DATA_W-1]
        && wr_data[bbc_pkg::DATA_W-1] == dst_val[0])
        else $error("reverse end bits wrong");
    a_set_bit: assert property (
        @(posedge mclk_in) disable iff (!rst_b_in)
        fire && is_set |-> wr.wr_en && wr_data[five_bit_literal]
        && (wr_data & dst_val) == dst_val
        && $countones(wr_data ^ dst_val) <= 1)
        else $error("bit set touched other bits");
    a_tst_keep: assert property (
        @(posedge mclk_in) disable iff (!rst_b_in)
        fire && is_tst |-> !wr.wr_en)
        else $error("bit test wrote a register");
    a_clrt_gate: assert property (
        @(posedge mclk_in) disable iff (!rst_b_in)
        fire && is_clrt |-> wr.wr_en == flag_reg
        && wr_data == bbc_pkg::ZERO_W)
        else $error("clear-if-true gating wrong");
    a_clrf_gate: assert property (
        @(posedge mclk_in) disable iff (!rst_b_in)
        fire && is_clrf |-> wr.wr_en == !flag_reg
        && wr_data == bbc_pkg::ZERO_W)
        else $error("clear-if-false gating wrong");

    // condition flag
    a_flag_hold: assert property (
        @(posedge mclk_in) disable iff (!rst_b_in)
        ce_in && !(fire && (is_tst || is_cmpu || is_cmps))
        |=> $stable(flag_reg))
        else $error("flag changed unexpectedly");
    a_cmpu_flag: assert property (
        @(posedge mclk_in) disable iff (!rst_b_in)
        fire && is_cmpu
        |=> flag_reg == ($past(dst_val) >= $past(src_val)))
        else $error("unsigned compare flag wrong");
    a_cmps_flag: assert property (
        @(posedge mclk_in) disable iff (!rst_b_in)
        fire && is_cmps |=> flag_reg
        == ($signed($past(dst_val)) < $signed($past(src_val))))
        else $error("signed compare flag wrong");

endmodule : bit_branch_compare_exec

// ===== bench/fetch_model.sv
// file: fetch stage model, offers one opcode with its pc per request
// assumes: caller is in the core clock domain, clock enable held high
`timescale 1ns/100ps
module fetch_model (
    // clock
    input wire logic mclk_in,
    // opcode toward the slice
    output bbc_pkg::fetch_t fetch_out
);
    initial fetch_out = '0;

    // hold valid for one edge, then release with inverted leftovers
    task automatic issue(input logic [15:0] op, input logic [31:0] pc);
        @(posedge mclk_in);
        fetch_out <= '{valid: 1'b1, opcode: op, pc: pc};
        @(posedge mclk_in);
        fetch_out <= '{valid: 1'b0, opcode: ~op, pc: ~pc};
    endtask : issue
endmodule : fetch_model

// ===== bench/tb_bit_branch_compare_exec.sv
// file: self-checking bench for the bit, branch and compare slice
// assumes: registers start at zero and are built up by slice opcodes
`timescale 1ns/100ps
module tb_bit_branch_compare_exec;
    logic mclk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic ce_in = 1'b1;
    logic [3:0] dbg_sel_in = 4'h0;
    bbc_pkg::fetch_t fetch_in;
    bbc_pkg::flow_t flow_out;
    logic exec_done_out;
    logic flag_out;
    logic [31:0] dbg_data_out;
    bbc_pkg::flow_t flow_seen;
    logic done_seen;
    logic flag_seen;
    int num_errors = 0;
    int checks_done = 0;

    // ------------------------------------------------------------
    // clock, model and design
    // ------------------------------------------------------------
    always #50 mclk_in = ~mclk_in;

    fetch_model u_fetch_model (.mclk_in(mclk_in), .fetch_out(fetch_in));

    bit_branch_compare_exec u_bit_branch_compare_exec (
        .mclk_in(mclk_in), .rst_b_in(rst_b_in), .ce_in(ce_in),
        .fetch_in(fetch_in), .flow_out(flow_out),
        .exec_done_out(exec_done_out), .flag_out(flag_out),
        .dbg_sel_in(dbg_sel_in), .dbg_data_out(dbg_data_out));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask : chk

    // execute one opcode and capture the one-cycle answer
    task automatic run(input logic [15:0] op, input logic [31:0] pc);
        u_fetch_model.issue(op, pc);
        #1;
        flow_seen = flow_out;
        done_seen = exec_done_out;
        flag_seen = flag_out;
    endtask : run

    task automatic cflag(input logic exp);
        chk({31'h0000_0000, flag_seen}, {31'h0000_0000, exp});
    endtask : cflag

    // read a register through the observation port, valid low
    task automatic creg(input logic [3:0] sel, input logic [31:0] exp);
        @(posedge mclk_in);
        dbg_sel_in <= sel;
        @(posedge mclk_in);
        #1;
        chk(dbg_data_out, exp);
    endtask : creg

    // branch target reckoned from pc and an 11-bit displacement
    function automatic logic [31:0] tgt(input logic [31:0] pc,
                                        input logic [10:0] d);
        tgt = pc + 32'h0000_0002 + {{20{d[10]}}, d, 1'b0};
    endfunction : tgt

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        chk({31'h0000_0000, flag_out}, 32'h0000_0000);
        for (int i = 0; i < 16; i++) begin
            creg(4'(i), 32'h0000_0000);
        end
        $display("test reset done");
    endtask : t_reset

    // masks at the literal edges, refused literals, flag kept
    task automatic t_mask;
        run(16'h0C00, 32'h0000_0100);
        cflag(1'b1);
        run({bbc_pkg::OPC_MASK, 5'h00, 4'h1}, 32'h0000_0102);
        cflag(1'b1);
        run({bbc_pkg::OPC_MASK, 5'h08, 4'h2}, 32'h0000_0104);
        run({bbc_pkg::OPC_MASK, 5'h1F, 4'h3}, 32'h0000_0106);
        for (int l = 1; l < 8; l++) begin
            run({bbc_pkg::OPC_MASK, 5'(l), 4'h4}, 32'h0000_0108);
            chk(32'(flow_seen.illegal), 32'h0000_0001);
        end
        creg(4'h1, 32'hFFFF_FFFF);
        creg(4'h2, 32'h0000_00FF);
        creg(4'h3, 32'h7FFF_FFFF);
        creg(4'h4, 32'h0000_0000);
        $display("test mask done");
    endtask : t_mask

    // one-hot from a built source, high bits ignored, bit 5 clears
    task automatic t_onehot;
        run({bbc_pkg::OPC_BITSET, 5'h04, 4'h5}, 32'h0000_0200);
        run({bbc_pkg::OPC_BITSET, 5'h00, 4'h5}, 32'h0000_0202);
        run({bbc_pkg::OPC_BITSET, 5'h1F, 4'h5}, 32'h0000_0204);
        creg(4'h5, 32'h8000_0011);
        run({bbc_pkg::OPC_ONEHOT, 4'h5, 4'hF}, 32'h0000_0206);
        chk({31'h0000_0000, done_seen}, 32'h0000_0001);
        cflag(1'b1);
        run({bbc_pkg::OPC_ONEHOT, 4'h1, 4'h2}, 32'h0000_0208);
        creg(4'hF, 32'h0002_0000);
        creg(4'h2, 32'h0000_0000);
        $display("test onehot done");
    endtask : t_onehot

    // unsigned and signed compares, operand order and equality
    task automatic t_cmp;
        run(16'h0C13, 32'h0000_0300);
        cflag(1'b0);
        run(16'h0C31, 32'h0000_0302);
        cflag(1'b1);
        run(16'h0D33, 32'h0000_0304);
        cflag(1'b0);
        run(16'h0C33, 32'h0000_0306);
        cflag(1'b1);
        run(16'h0D31, 32'h0000_0308);
        cflag(1'b1);
        run(16'h0D13, 32'h0000_030A);
        cflag(1'b0);
        $display("test compare done");
    endtask : t_cmp

    // reverse in place, bit test into the flag, set of the top bit
    task automatic t_bits;
        run({bbc_pkg::OPC_REVERSE, 4'h5}, 32'h0000_0400);
        cflag(1'b0);
        creg(4'h5, 32'h8800_0001);
        run({bbc_pkg::OPC_BITTST, 5'h1F, 4'h5}, 32'h0000_0402);
        cflag(1'b1);
        run({bbc_pkg::OPC_BITTST, 5'h1E, 4'h5}, 32'h0000_0404);
        cflag(1'b0);
        run({bbc_pkg::OPC_BITTST, 5'h00, 4'h5}, 32'h0000_0406);
        cflag(1'b1);
        creg(4'h5, 32'h8800_0001);
        run({bbc_pkg::OPC_BITSET, 5'h1F, 4'h3}, 32'h0000_0408);
        creg(4'h3, 32'hFFFF_FFFF);
        $display("test bits done");
    endtask : t_bits

    // both conditional clears under both flag values
    task automatic t_clear;
        run({bbc_pkg::OPC_CLR_F, 4'h3}, 32'h0000_0500);
        creg(4'h3, 32'hFFFF_FFFF);
        run({bbc_pkg::OPC_CLR_T, 4'h3}, 32'h0000_0502);
        creg(4'h3, 32'h0000_0000);
        run({bbc_pkg::OPC_BITTST, 5'h00, 4'h0}, 32'h0000_0504);
        run({bbc_pkg::OPC_CLR_T, 4'h1}, 32'h0000_0506);
        creg(4'h1, 32'hFFFF_FFFF);
        run({bbc_pkg::OPC_CLR_F, 4'h1}, 32'h0000_0508);
        cflag(1'b0);
        creg(4'h1, 32'h0000_0000);
        $display("test clear done");
    endtask : t_clear

    // jumps at displacement extremes, call link, conditional, break
    task automatic t_branch;
        run({bbc_pkg::OPC_JUMP, 11'h7FF}, 32'h0000_1000);
        chk(flow_seen.pc_next, tgt(32'h0000_1000, 11'h7FF));
        chk(32'(flow_seen.pc_load), 32'h0000_0001);
        chk(32'(flow_seen.illegal), 32'h0000_0000);
        run({bbc_pkg::OPC_JUMP, 11'h400}, 32'h0000_1000);
        chk(flow_seen.pc_next, tgt(32'h0000_1000, 11'h400));
        run({bbc_pkg::OPC_JUMP, 11'h3FF}, 32'h0000_1000);
        chk(flow_seen.pc_next, tgt(32'h0000_1000, 11'h3FF));
        run({bbc_pkg::OPC_CALL, 11'h001}, 32'h0000_2000);
        chk(flow_seen.pc_next, tgt(32'h0000_2000, 11'h001));
        creg(4'hF, 32'h0000_2002);
        run({bbc_pkg::OPC_JUMP_T, 11'h010}, 32'h0000_3000);
        chk(flow_seen.pc_next, 32'h0000_3002);
        run(16'h0C00, 32'h0000_3002);
        run({bbc_pkg::OPC_JUMP_T, 11'h010}, 32'h0000_3000);
        chk(flow_seen.pc_next, tgt(32'h0000_3000, 11'h010));
        cflag(1'b1);
        run(16'h0000, 32'h0000_4000);
        chk(32'(flow_seen.breakpoint), 32'h0000_0001);
        $display("test branch done");
    endtask : t_branch

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        t_reset();
        t_mask();
        t_onehot();
        t_cmp();
        t_bits();
        t_clear();
        t_branch();
        test_done();
    end

    initial begin
        repeat (4000) @(posedge mclk_in);
        num_errors++;
        test_done();
    end
endmodule : tb_bit_branch_compare_exec
